// >>> design/psrm_pkg.sv
// Package: register map constants and carrier types for the pressure sensor register bank
package psrm_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int SUB_W = 8;

  localparam logic [6:0] OFS_REF_LOW = 7'h08;
  localparam logic [6:0] OFS_REF_MID = 7'h09;
  localparam logic [6:0] OFS_REF_HIGH = 7'h0a;
  localparam logic [6:0] OFS_IDENTITY = 7'h0f;
  localparam logic [6:0] OFS_AVG_CFG = 7'h10;
  localparam logic [6:0] OFS_CTRL_ONE = 7'h20;
  localparam logic [6:0] OFS_CTRL_TWO = 7'h21;
  localparam logic [6:0] OFS_CTRL_THREE = 7'h22;
  localparam logic [6:0] OFS_CTRL_FOUR = 7'h23;
  localparam logic [6:0] OFS_IRQ_SETUP = 7'h24;
  localparam logic [6:0] OFS_IRQ_CAUSE = 7'h25;
  localparam logic [6:0] OFS_SAMPLE_STAT = 7'h27;
  localparam logic [6:0] OFS_PRESS_LOW = 7'h28;
  localparam logic [6:0] OFS_PRESS_MID = 7'h29;
  localparam logic [6:0] OFS_PRESS_HIGH = 7'h2a;
  localparam logic [6:0] OFS_TEMP_LOW = 7'h2b;
  localparam logic [6:0] OFS_TEMP_HIGH = 7'h2c;
  localparam logic [6:0] OFS_QUEUE_CTRL = 7'h2e;
  localparam logic [6:0] OFS_QUEUE_STAT = 7'h2f;
  localparam logic [6:0] OFS_THS_LOW = 7'h30;
  localparam logic [6:0] OFS_THS_HIGH = 7'h31;
  localparam logic [6:0] OFS_AZ_LOW = 7'h39;
  localparam logic [6:0] OFS_AZ_HIGH = 7'h3a;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AVG_CFG = 8'h05;
  // Arbitrary neutral identity value
  localparam logic [7:0] IDENTITY_CODE = 8'h5a;
  localparam logic [7:0] READ_FILL = 8'h00;

  localparam int SUB_INC_BIT = 7;
  localparam int CTRL_ONE_DIFF_BIT = 3;

  // One access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } psrm_req_t;

  // Sensor results feeding the readable bank
  typedef struct packed {
    logic valid;
    logic [23:0] pressure;
    logic [15:0] temperature;
  } psrm_sample_t;
endpackage

// >>> design/psrm_addr_seq.sv
// Register pointer: loads from the sub-address, optionally advances per byte
`timescale 1ns/1ns
`default_nettype none
module psrm_addr_seq
  import psrm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic sub_load,
  input wire logic [SUB_W-1:0] sub_byte,
  input wire logic byte_done,
  // Pointer
  output logic [ADDR_W-1:0] addr
);
  logic [ADDR_W-1:0] addr_r;
  logic inc_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 7'h00;
      inc_r <= 1'b0;
    end else if (sub_load) begin
      addr_r <= sub_byte[ADDR_W-1:0];
      inc_r <= sub_byte[SUB_INC_BIT];
    end else if (byte_done && inc_r) begin
      addr_r <= addr_r + 7'h01;
    end
  end

  assign addr = addr_r;
endmodule // psrm_addr_seq
`default_nettype wire

// >>> design/psrm_ref_sub.sv
// Signed difference of a measurement and the reference pressure
`timescale 1ns/1ns
`default_nettype none
module psrm_ref_sub
  import psrm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Operands
  input wire logic sample_valid,
  input wire logic [23:0] measured,
  input wire logic [23:0] reference,
  // Result
  output logic diff_valid,
  output logic signed [23:0] diff
);
  logic signed [23:0] diff_r;
  logic valid_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      diff_r <= 24'sh00_0000;
      valid_r <= 1'b0;
    end else begin
      valid_r <= sample_valid;
      if (sample_valid) begin
        diff_r <= $signed(measured) - $signed(reference);
      end
    end
  end

  assign diff = diff_r;
  assign diff_valid = valid_r;
endmodule // psrm_ref_sub
`default_nettype wire

// >>> design/psrm_regbank.sv
// Register bank of the barometric pressure sensor
// Notes on behaviour
// - Every register is eight bits wide; used for configuration and results.
// - Each register is selected by a seven-bit address for reads and writes.
// - Registers drive sensor control and expose pressure and temperature results.
// - Calibration registers reload from their factory image on power-up.
// - Reference pressure is one signed 24-bit two's-complement value.
// - Reference bytes: low at 08h, mid at 09h, high at 0Ah, all read/write.
// - Reference is subtracted from each measurement for thresholds and autozero.
// - Sub-address low seven bits pick register; top bit enables increment.
`timescale 1ns/1ns
`default_nettype none
module psrm_regbank
  import psrm_pkg::*;
#(
  parameter int CAL_REGS = 4,
  parameter logic [8*CAL_REGS-1:0] CAL_IMAGE = '0
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial front end access
  input wire logic sub_load,
  input wire logic [SUB_W-1:0] sub_byte,
  input wire psrm_req_t req,
  output logic [DATA_W-1:0] rdata,
  // Sensor core results
  input wire psrm_sample_t sample,
  input wire logic [7:0] cause_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] queue_stat_in,
  // Control outputs to sensor core
  output logic [7:0] avg_cfg,
  output logic [7:0] ctrl_one,
  output logic [7:0] ctrl_two,
  output logic [7:0] ctrl_three,
  output logic [7:0] ctrl_four,
  output logic [7:0] irq_setup,
  output logic [7:0] queue_ctrl,
  output logic [15:0] threshold,
  output logic [15:0] autozero_ref,
  output logic [8*CAL_REGS-1:0] cal_trim,
  // Difference output
  output logic diff_valid,
  output logic signed [23:0] diff
);
  // Elaboration guard on the calibration image size
  if (CAL_REGS < 1 || CAL_REGS > 16) begin : g_cal_check
    $error("CAL_REGS out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pointer
  logic [ADDR_W-1:0] addr;
  logic byte_done;

  assign byte_done = req.wr | req.rd;

  psrm_addr_seq u_addr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sub_load(sub_load),
    .sub_byte(sub_byte),
    .byte_done(byte_done),
    .addr(addr)
  );

  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction

  // Offsets that take host writes; read-only, reserved and unlisted never do
  function automatic logic writable(input logic [6:0] a);
    writable = 1'b0;
    if (hit(a, OFS_REF_LOW) || hit(a, OFS_REF_MID) || hit(a, OFS_REF_HIGH)) begin
      writable = 1'b1;
    end else if (hit(a, OFS_AVG_CFG)) begin
      writable = 1'b1;
    end else if (hit(a, OFS_CTRL_ONE) || hit(a, OFS_CTRL_TWO)) begin
      writable = 1'b1;
    end else if (hit(a, OFS_CTRL_THREE) || hit(a, OFS_CTRL_FOUR)) begin
      writable = 1'b1;
    end else if (hit(a, OFS_IRQ_SETUP) || hit(a, OFS_QUEUE_CTRL)) begin
      writable = 1'b1;
    end else if (hit(a, OFS_THS_LOW) || hit(a, OFS_THS_HIGH)) begin
      writable = 1'b1;
    end else if (hit(a, OFS_AZ_LOW) || hit(a, OFS_AZ_HIGH)) begin
      writable = 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Writable registers
  logic [7:0] ref_low_r;
  logic [7:0] ref_mid_r;
  logic [7:0] ref_high_r;
  logic [7:0] avg_cfg_r;
  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_two_r;
  logic [7:0] ctrl_three_r;
  logic [7:0] ctrl_four_r;
  logic [7:0] irq_setup_r;
  logic [7:0] queue_ctrl_r;
  logic [7:0] ths_low_r;
  logic [7:0] ths_high_r;
  logic [7:0] az_low_r;
  logic [7:0] az_high_r;
  logic wr_ok;

  // Writes only land on mapped writable offsets; reserved and unlisted ignored
  assign wr_ok = req.wr && writable(addr);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_low_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_REF_LOW)) begin
      ref_low_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_mid_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_REF_MID)) begin
      ref_mid_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_high_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_REF_HIGH)) begin
      ref_high_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avg_cfg_r <= RST_AVG_CFG;
    end else if (wr_ok && hit(addr, OFS_AVG_CFG)) begin
      avg_cfg_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_CTRL_ONE)) begin
      ctrl_one_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_CTRL_TWO)) begin
      ctrl_two_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_three_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_CTRL_THREE)) begin
      ctrl_three_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_four_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_CTRL_FOUR)) begin
      ctrl_four_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_setup_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_IRQ_SETUP)) begin
      irq_setup_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      queue_ctrl_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_QUEUE_CTRL)) begin
      queue_ctrl_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ths_low_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_THS_LOW)) begin
      ths_low_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ths_high_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_THS_HIGH)) begin
      ths_high_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      az_low_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_AZ_LOW)) begin
      az_low_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      az_high_r <= RST_ZERO;
    end else if (wr_ok && hit(addr, OFS_AZ_HIGH)) begin
      az_high_r <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Factory calibration image, restored on every power-up
  logic [8*CAL_REGS-1:0] cal_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_r <= CAL_IMAGE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result capture
  logic [23:0] press_r;
  logic [15:0] temp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      press_r <= 24'h00_0000;
      temp_r <= 16'h0000;
    end else if (sample.valid) begin
      press_r <= sample.pressure;
      temp_r <= sample.temperature;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference subtraction
  logic [23:0] reference;

  assign reference = {ref_high_r, ref_mid_r, ref_low_r};

  psrm_ref_sub u_sub (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sample_valid(sample.valid),
    .measured(sample.pressure),
    .reference(reference),
    .diff_valid(diff_valid),
    .diff(diff)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_nxt;
  logic [7:0] rdata_r;

  always_comb begin
    rd_nxt = READ_FILL;
    if (hit(addr, OFS_REF_LOW)) begin
      rd_nxt = ref_low_r;
    end else if (hit(addr, OFS_REF_MID)) begin
      rd_nxt = ref_mid_r;
    end else if (hit(addr, OFS_REF_HIGH)) begin
      rd_nxt = ref_high_r;
    end else if (hit(addr, OFS_IDENTITY)) begin
      rd_nxt = IDENTITY_CODE;
    end else if (hit(addr, OFS_AVG_CFG)) begin
      rd_nxt = avg_cfg_r;
    end else if (hit(addr, OFS_CTRL_ONE)) begin
      rd_nxt = ctrl_one_r;
    end else if (hit(addr, OFS_CTRL_TWO)) begin
      rd_nxt = ctrl_two_r;
    end else if (hit(addr, OFS_CTRL_THREE)) begin
      rd_nxt = ctrl_three_r;
    end else if (hit(addr, OFS_CTRL_FOUR)) begin
      rd_nxt = ctrl_four_r;
    end else if (hit(addr, OFS_IRQ_SETUP)) begin
      rd_nxt = irq_setup_r;
    end else if (hit(addr, OFS_IRQ_CAUSE)) begin
      rd_nxt = cause_in;
    end else if (hit(addr, OFS_SAMPLE_STAT)) begin
      rd_nxt = status_in;
    end else if (hit(addr, OFS_PRESS_LOW)) begin
      rd_nxt = press_r[7:0];
    end else if (hit(addr, OFS_PRESS_MID)) begin
      rd_nxt = press_r[15:8];
    end else if (hit(addr, OFS_PRESS_HIGH)) begin
      rd_nxt = press_r[23:16];
    end else if (hit(addr, OFS_TEMP_LOW)) begin
      rd_nxt = temp_r[7:0];
    end else if (hit(addr, OFS_TEMP_HIGH)) begin
      rd_nxt = temp_r[15:8];
    end else if (hit(addr, OFS_QUEUE_CTRL)) begin
      rd_nxt = queue_ctrl_r;
    end else if (hit(addr, OFS_QUEUE_STAT)) begin
      rd_nxt = queue_stat_in;
    end else if (hit(addr, OFS_THS_LOW)) begin
      rd_nxt = ths_low_r;
    end else if (hit(addr, OFS_THS_HIGH)) begin
      rd_nxt = ths_high_r;
    end else if (hit(addr, OFS_AZ_LOW)) begin
      rd_nxt = az_low_r;
    end else if (hit(addr, OFS_AZ_HIGH)) begin
      rd_nxt = az_high_r;
    end
  end

  // Read data registered on the read strobe, 7-bit address selects byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RST_ZERO;
    end else if (req.rd) begin
      rdata_r <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata = rdata_r;
  assign avg_cfg = avg_cfg_r;
  assign ctrl_one = ctrl_one_r;
  assign ctrl_two = ctrl_two_r;
  assign ctrl_three = ctrl_three_r;
  assign ctrl_four = ctrl_four_r;
  assign irq_setup = irq_setup_r;
  assign queue_ctrl = queue_ctrl_r;
  assign threshold = {ths_high_r, ths_low_r};
  assign autozero_ref = {az_high_r, az_low_r};
  assign cal_trim = cal_r;
endmodule // psrm_regbank
`default_nettype wire

// >>> bench/psrm_regbank_asserts.sv
// Port assertions for the pressure sensor register bank
`timescale 1ns/1ns
`default_nettype none
module psrm_regbank_asserts
  import psrm_pkg::*;
#(
  parameter int CAL_REGS = 4,
  parameter logic [8*CAL_REGS-1:0] CAL_IMAGE = '0
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Access
  input wire logic sub_load,
  input wire logic [SUB_W-1:0] sub_byte,
  input wire psrm_req_t req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [7:0] cause_in,
  // Sample path
  input wire psrm_sample_t sample,
  input wire logic diff_valid,
  // Registers
  input wire logic [7:0] avg_cfg,
  input wire logic [7:0] ctrl_one,
  input wire logic [15:0] threshold,
  input wire logic [8*CAL_REGS-1:0] cal_trim
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_dv; sample.valid |=> diff_valid; endproperty
  a_dv: assert property (p_dv) else $error("diff_valid missing");
  property p_dq; !sample.valid |=> !diff_valid; endproperty
  a_dq: assert property (p_dq) else $error("diff_valid spurious");
  property p_cal; cal_trim == CAL_IMAGE; endproperty
  a_cal: assert property (p_cal) else $error("cal_trim changed");
  property p_rh; !req.rd |=> $stable(rdata); endproperty
  a_rh: assert property (p_rh) else $error("rdata moved");
  property p_ct; !req.wr |=> $stable(ctrl_one); endproperty
  a_ct: assert property (p_ct) else $error("ctrl_one moved");
  property p_id; sub_load && sub_byte[6:0] == OFS_IDENTITY ##1 !sub_load
    ##1 req.rd && !sub_load |=> rdata == IDENTITY_CODE; endproperty
  a_id: assert property (p_id) else $error("bad identity");
  property p_cz; sub_load && sub_byte[6:0] == OFS_IRQ_CAUSE ##1 !sub_load
    ##1 req.rd && !sub_load |=> rdata == $past(cause_in); endproperty
  a_cz: assert property (p_cz) else $error("bad cause read");
  property p_av; sub_load && sub_byte == 8'h10 ##1 !sub_load
    ##1 req.wr && !sub_load |=> avg_cfg == $past(req.wdata); endproperty
  a_av: assert property (p_av) else $error("avg_cfg not written");
  property p_th; sub_load && sub_byte == 8'hb0 ##2 req.wr && !sub_load ##2 req.wr
    && !sub_load |=> threshold == {$past(req.wdata), $past(req.wdata, 3)}; endproperty
  a_th: assert property (p_th) else $error("threshold bytes");
endmodule // psrm_regbank_asserts

bind psrm_regbank psrm_regbank_asserts #(.CAL_REGS(CAL_REGS), .CAL_IMAGE(CAL_IMAGE))
  psrm_regbank_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .sub_load(sub_load),
  .sub_byte(sub_byte), .req(req), .rdata(rdata), .cause_in(cause_in), .sample(sample),
  .diff_valid(diff_valid), .avg_cfg(avg_cfg), .ctrl_one(ctrl_one),
  .threshold(threshold), .cal_trim(cal_trim));
`default_nettype wire

// >>> bench/psrm_host.sv
// Host model issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module psrm_host
  import psrm_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requests
  output logic sub_load,
  output logic [SUB_W-1:0] sub_byte,
  output var psrm_req_t req,
  // Answer
  input wire logic [DATA_W-1:0] rdata
);
  initial begin
    sub_load = 1'b0;
    sub_byte = 8'h00;
    req = '0;
  end
  // Released lines show the inverse of their last value
  task automatic point(input logic [7:0] s);
    @(negedge clk_sys);
    sub_load = 1'b1;
    sub_byte = s;
    @(negedge clk_sys);
    sub_load = 1'b0;
    sub_byte = ~s;
  endtask
  // Writes at the pointer; callers keep it off reserved and unlisted offsets
  task automatic wr(input logic [7:0] d);
    @(negedge clk_sys);
    req.wr = 1'b1;
    req.wdata = d;
    @(negedge clk_sys);
    req.wr = 1'b0;
    req.wdata = ~d;
    req.addr = ~req.addr;
  endtask
  task automatic rd(output logic [7:0] d);
    @(negedge clk_sys);
    req.rd = 1'b1;
    @(negedge clk_sys);
    req.rd = 1'b0;
    d = rdata;
  endtask
endmodule // psrm_host
`default_nettype wire

// >>> bench/psrm_tb_top.sv
// Self-checking bench for the pressure sensor register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h exp %h", $time, g, e); end end
module psrm_tb_top
  import psrm_pkg::*;
;
  localparam logic [15:0] CAL = 16'hc3a5;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sub_load;
  logic [SUB_W-1:0] sub_byte;
  psrm_req_t req;
  logic [DATA_W-1:0] rdata;
  psrm_sample_t sample = '0;
  logic [7:0] cause_in = 8'h00, status_in = 8'h00, queue_stat_in = 8'h00;
  logic [7:0] avg_cfg, ctrl_one, ctrl_two, ctrl_three, ctrl_four, irq_setup, queue_ctrl;
  logic [15:0] threshold, autozero_ref, cal_trim;
  logic diff_valid;
  logic signed [23:0] diff;
  logic [7:0] mdl [0:127];
  logic [23:0] pr;
  logic [15:0] tp;
  logic [31:0] seed = 32'h98b9_4ae2;
  int errors = 0;
  int checks = 0;
  always #4 clk_sys = ~clk_sys;
  psrm_host psrm_host_i (.clk_sys(clk_sys), .sub_load(sub_load), .sub_byte(sub_byte),
    .req(req), .rdata(rdata));
  psrm_regbank #(.CAL_REGS(2), .CAL_IMAGE(CAL)) psrm_regbank_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .sub_load(sub_load), .sub_byte(sub_byte), .req(req), .rdata(rdata),
    .sample(sample), .cause_in(cause_in), .status_in(status_in),
    .queue_stat_in(queue_stat_in), .avg_cfg(avg_cfg), .ctrl_one(ctrl_one),
    .ctrl_two(ctrl_two), .ctrl_three(ctrl_three), .ctrl_four(ctrl_four),
    .irq_setup(irq_setup), .queue_ctrl(queue_ctrl), .threshold(threshold),
    .autozero_ref(autozero_ref), .cal_trim(cal_trim), .diff_valid(diff_valid), .diff(diff));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit rw(input logic [6:0] a);
    return a inside {[7'h08:7'h0a], 7'h10, [7'h20:7'h24], 7'h2e, 7'h30, 7'h31, 7'h39, 7'h3a};
  endfunction
  // Host keeps writes off reserved offsets and every access off unlisted ones
  function automatic bit ok(input logic [6:0] a, input bit w);
    if (a > 7'h3a || a inside {7'h0b, 7'h0c}) return 1'b0;
    if (a inside {[7'h00:7'h07], 7'h0d, 7'h0e, [7'h11:7'h1f]}) return !w;
    return !w || !(a inside {7'h26, 7'h2d, [7'h32:7'h38]});
  endfunction
  function automatic logic [7:0] ex(input logic [6:0] a);
    if (rw(a)) return mdl[a];
    case (a)
      7'h0f: return IDENTITY_CODE;
      7'h25: return cause_in;
      7'h27: return status_in;
      7'h2f: return queue_stat_in;
      7'h28: return pr[7:0];
      7'h29: return pr[15:8];
      7'h2a: return pr[23:16];
      7'h2b: return tp[7:0];
      7'h2c: return tp[15:8];
      default: return 8'h00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic boot();
    rst_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[16] = 8'h05;
    pr = '0;
    tp = '0;
    rst_n = 1'b1;
  endtask
  task automatic sweep(input bit w, input logic [7:0] s, input int n);
    logic [6:0] a;
    logic [7:0] v;
    bit moved;
    a = s[6:0];
    moved = 1'b1;
    repeat (n) begin
      if (!ok(a, w)) begin
        moved = 1'b1;
      end else begin
        // Pointer stands still over a skipped offset, so reload it
        if (moved) psrm_host_i.point({s[7], a});
        moved = 1'b0;
        if (w) begin
          v = 8'(xs());
          psrm_host_i.wr(v);
          if (rw(a)) mdl[a] = v;
        end else begin
          psrm_host_i.rd(v);
          `CHK(v, ex(a))
        end
      end
      if (s[7]) a = a + 7'h01;
    end
  endtask
  task automatic outs();
    `CHK({avg_cfg, ctrl_one, ctrl_two, ctrl_three}, {mdl[16], mdl[32], mdl[33], mdl[34]})
    `CHK({ctrl_four, irq_setup, queue_ctrl}, {mdl[35], mdl[36], mdl[46]})
    `CHK({threshold, autozero_ref}, {mdl[49], mdl[48], mdl[58], mdl[57]})
    `CHK(cal_trim, CAL)
  endtask
  task automatic samp(input logic [23:0] p);
    logic [23:0] rf;
    rf = {mdl[10], mdl[9], mdl[8]};
    @(negedge clk_sys);
    pr = p;
    tp = 16'(xs());
    sample = '{1'b1, p, tp};
    @(negedge clk_sys);
    `CHK(diff_valid, 1'b1)
    `CHK(diff, p - rf)
    sample.valid = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    boot();
    outs();
    sweep(1'b0, 8'h80, 128);
    $display("test reset_values done");
    cause_in = 8'(xs());
    status_in = 8'(xs());
    queue_stat_in = 8'(xs());
    sweep(1'b1, 8'h80, 128);
    outs();
    sweep(1'b0, 8'h80, 128);
    sweep(1'b0, 8'h0f, 1);
    sweep(1'b0, 8'h25, 1);
    $display("test write_all done");
    sweep(1'b1, 8'h10, 2);
    sweep(1'b0, 8'h10, 2);
    sweep(1'b0, 8'h8e, 3);
    sweep(1'b1, 8'hb0, 2);
    outs();
    $display("test pointer done");
    psrm_host_i.point(8'h20);
    psrm_host_i.wr(8'h08);
    mdl[32] = 8'h08;
    repeat (4) begin
      sweep(1'b1, 8'h88, 3);
      samp(24'(xs()));
      samp(24'h80_0000);
    end
    sweep(1'b0, 8'ha8, 5);
    $display("test samples done");
    boot();
    outs();
    sweep(1'b0, 8'h80, 128);
    $display("test second_reset done");
    wrap_up();
  end
  initial begin
    #(8 * 20000);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // psrm_tb_top
`default_nettype wire
